// file: rtl/ast_tx.sv
/*
 * Audio serial transmit framer: TDM, I2S and left-justified output,
 * slave to an external bit clock and frame sync, set up over Avalon-MM.
 * Assumes bit clock well below a quarter of i_clk; the pins are
 * sampled, so the data edge trails the bit-clock edge by 3-4 clocks, 2-3 in late mode.
 */
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
module ast_tx (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// register bus
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// audio link
	input  wire logic        i_bclk,
	input  wire logic        i_frame_sync,
	output logic             o_sdout,
	output logic             o_sdout_oe,
	output logic             o_sdout_keep,
	output logic             o_sdout_keep_en,
	// shared pins
	input  wire logic        i_multipurpose_pin,
	output logic             o_multipurpose_pin,
	output logic             o_multipurpose_pin_oe,
	output logic             o_general_output_pin,
	input  wire logic        i_general_input_pin
);

	localparam int N = ast_pkg::NUM_CH;

	ast_pkg::ast_cfg_t          cfg_reg;
	logic [N-1:0][5:0]          slot_cfg_reg;
	logic [N-1:0][31:0]         hold_reg;
	logic [N-1:0][31:0]         word_reg;
	logic [31:0]                rd_mux;
	logic [31:0]                merged;
	logic                       wr_take;

	logic [3:0]                 pin_s;
	logic                       bclk_eff;
	logic                       fs_eff;
	logic                       bclk_prev_reg;
	logic                       fs_prev_reg;
	logic                       rise;
	logic                       fall;
	logic                       launch;
	logic                       sample;
	logic                       fs_up;
	logic                       fs_dn;
	logic                       is_tdm;
	logic                       is_i2s;
	logic                       is_lj;
	logic                       left_start;
	logic                       right_start;
	logic                       start;
	logic [5:0]                 start_dly;
	logic [4:0]                 wtop;

	ast_pkg::ast_state_t        state_reg;
	logic [5:0]                 dly_reg;
	logic [5:0]                 slot_reg;
	logic [4:0]                 bit_reg;
	logic [15:0]                frame_cnt_reg;
	logic                       emit_first;
	logic                       emit_run;
	logic                       emit_idle;
	logic                       emit_bit;
	logic                       last_slot;
	logic [5:0]                 cur_slot;
	logic [4:0]                 cur_bit;
	logic                       l1_own;
	logic                       l1_bit;
	logic                       l2_own;
	logic                       l2_bit;
	logic                       daisy_bit;
	ast_pkg::ast_lane_t         stg1_reg;
	ast_pkg::ast_lane_t         stg2_reg;
	logic                       emit_d_reg;
	logic                       copy;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
	                                         input logic [31:0] new_v,
	                                         input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// bus slave: one wait cycle, then answer
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0;
		end else if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
			o_avs_waitrequest <= 1'b0;
			if (i_avs_read) begin
				o_avs_readdata <= rd_mux;
			end
		end else begin
			o_avs_waitrequest <= 1'b1;
		end
	end

	assign wr_take = i_avs_write & ~o_avs_waitrequest;
	assign merged  = be_merge(rd_mux, i_avs_writedata, i_avs_byteenable);

	always_comb begin
		rd_mux = 32'h0;
		unique case (i_avs_address)
			ast_pkg::ADDR_CTRL:   rd_mux = {9'h0, cfg_reg};
			ast_pkg::ADDR_SLOT: begin
				for (int c = 0; c < N; c++) begin
					rd_mux[c*ast_pkg::SLOT_STRIDE +: 6] = slot_cfg_reg[c];
				end
			end
			ast_pkg::ADDR_DATA0:  rd_mux = hold_reg[0];
			ast_pkg::ADDR_DATA1:  rd_mux = hold_reg[1];
			ast_pkg::ADDR_DATA2:  rd_mux = hold_reg[2];
			ast_pkg::ADDR_DATA3:  rd_mux = hold_reg[3];
			ast_pkg::ADDR_STATUS: begin
				rd_mux = {8'h0, frame_cnt_reg, 1'b0,
				          (state_reg != ast_pkg::AST_IDLE), slot_reg};
			end
			default:              rd_mux = 32'h0;
		endcase
	end

	// word length field, 32 at reset
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			cfg_reg      <= ast_pkg::ast_cfg_t'(ast_pkg::CTRL_RST);
			slot_cfg_reg <= '0;
			hold_reg     <= '0;
		end else if (wr_take) begin
			if (i_avs_address == ast_pkg::ADDR_CTRL) begin
				cfg_reg <= ast_pkg::ast_cfg_t'(merged[ast_pkg::CTRL_BITS-1:0]);
			end
			if (i_avs_address == ast_pkg::ADDR_SLOT) begin
				for (int c = 0; c < N; c++) begin
					slot_cfg_reg[c] <= merged[c*ast_pkg::SLOT_STRIDE +: 6];
				end
			end
			for (int c = 0; c < N; c++) begin
				if (i_avs_address == ast_pkg::ADDR_DATA0 + 5'(4 * c)) begin
					hold_reg[c] <= merged;
				end
			end
		end
	end

	ast_sync #(
		.WIDTH (4)
	) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_d      ({i_general_input_pin, i_multipurpose_pin,
		            i_frame_sync, i_bclk}),
		.o_q      (pin_s)
	);

	assign is_tdm = cfg_reg.frame_format_select == ast_pkg::FMT_TDM;
	assign is_i2s = cfg_reg.frame_format_select == ast_pkg::FMT_I2S;
	assign is_lj  = cfg_reg.frame_format_select == ast_pkg::FMT_LJ;

	assign bclk_eff = pin_s[0] ^ cfg_reg.bit_clock_invert;
	assign fs_eff   = pin_s[1] ^ cfg_reg.frame_sync_invert;
	assign rise     = bclk_eff & ~bclk_prev_reg;
	assign fall     = ~bclk_eff & bclk_prev_reg;

	assign launch = is_tdm ? rise : fall;
	assign sample = is_tdm ? fall : rise;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			bclk_prev_reg <= 1'b0;
		end else begin
			bclk_prev_reg <= bclk_eff;
		end
	end

	// only edges of sync matter, not width
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			fs_prev_reg <= 1'b0;
		end else if (sample) begin
			fs_prev_reg <= fs_eff;
		end
	end

	assign fs_up = sample & fs_eff & ~fs_prev_reg;
	assign fs_dn = sample & ~fs_eff & fs_prev_reg;

	// I2S left half on sync fall
	// LJ left half on sync rise
	assign left_start  = (is_tdm | is_lj) ? fs_up : (is_i2s & fs_dn);
	// I2S right half on sync rise
	// LJ right half on sync fall
	assign right_start = is_i2s ? fs_up : (is_lj & fs_dn);
	assign start       = cfg_reg.enable & (left_start | right_start);

	// extra delay applies to both halves
	// I2S standard timing is one cycle late
	assign start_dly = {1'b0, cfg_reg.slot_delay} + {5'h0, is_i2s};

	always_comb begin
		unique case (cfg_reg.word_length_select)
			ast_pkg::WLEN_16: wtop = ast_pkg::WTOP_16;
			ast_pkg::WLEN_20: wtop = ast_pkg::WTOP_20;
			ast_pkg::WLEN_24: wtop = ast_pkg::WTOP_24;
			ast_pkg::WLEN_32: wtop = ast_pkg::WTOP_32;
		endcase
	end

	// a half ends after slot 31 of its own
	// even if the phase runs longer
	assign last_slot = is_tdm ? (slot_reg == ast_pkg::SLOT_LAST)
	                          : (slot_reg[4:0] == ast_pkg::HALF_LAST);

	// zero delay puts msb out at the sync edge
	assign emit_first = start & (start_dly == 6'h00);
	assign emit_run   = launch & ~start &
	                    ((state_reg == ast_pkg::AST_SHIFT) |
	                     ((state_reg == ast_pkg::AST_DELAY) &
	                      (dly_reg == 6'h01)));
	assign emit_idle  = launch & ~start & ~emit_run;
	assign emit_bit   = emit_first | emit_run;

	assign cur_slot = start ? (left_start ? ast_pkg::SLOT_LEFT0
	                                      : ast_pkg::SLOT_RIGHT0)
	                        : slot_reg;
	assign cur_bit  = start ? 5'h00 : bit_reg;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state_reg <= ast_pkg::AST_IDLE;
			dly_reg   <= 6'h00;
			slot_reg  <= 6'h00;
			bit_reg   <= 5'h00;
		end else if (!cfg_reg.enable) begin
			state_reg <= ast_pkg::AST_IDLE;
		end else if (start) begin
			slot_reg <= cur_slot;
			dly_reg  <= start_dly;
			if (emit_first) begin
				state_reg <= ast_pkg::AST_SHIFT;
				bit_reg   <= 5'h01;
			end else begin
				state_reg <= ast_pkg::AST_DELAY;
				bit_reg   <= 5'h00;
			end
		end else if (emit_run) begin
			state_reg <= ast_pkg::AST_SHIFT;
			if (bit_reg == wtop) begin
				bit_reg <= 5'h00;
				if (last_slot) begin
					state_reg <= ast_pkg::AST_IDLE;
				end else begin
					slot_reg <= slot_reg + 6'h01;
				end
			end else begin
				bit_reg <= bit_reg + 5'h01;
			end
		end else if (launch && state_reg == ast_pkg::AST_DELAY) begin
			// count off the slot start delay
			dly_reg <= dly_reg - 6'h01;
		end
	end

	// words are taken once per frame; a zero-delay LJ right half still reads its first bit from hold_reg
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			word_reg      <= '0;
			frame_cnt_reg <= 16'h0;
		end else if (cfg_reg.enable & left_start) begin
			word_reg      <= hold_reg;
			frame_cnt_reg <= frame_cnt_reg + 16'h1;
		end
	end

	ast_chan_sel #(
		.N_CH (N)
	) u_sel (
		.i_slot     (cur_slot),
		.i_bit      (cur_bit),
		.i_slots    (slot_cfg_reg),
		.i_words    (start ? hold_reg : word_reg),
		.i_ch_en    (cfg_reg.ch_en),
		.i_lane2_en (cfg_reg.lane2_en),
		.o_l1_own   (l1_own),
		.o_l1_bit   (l1_bit),
		.o_l2_own   (l2_own),
		.o_l2_bit   (l2_bit)
	);

	assign daisy_bit = cfg_reg.daisy_on_mp ? pin_s[2] : pin_s[3];

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			stg1_reg <= '0;
			stg2_reg <= '0;
		end else if (!cfg_reg.enable) begin
			stg1_reg <= '0;
			stg2_reg <= '0;
		end else if (emit_bit & l1_own) begin
			stg1_reg <= '{o: l1_bit, oe: 1'b1};
			stg2_reg <= '{o: l2_bit, oe: l2_own | ~cfg_reg.tristate_en};
		end else if (emit_bit | emit_idle) begin
			// foreign slots pass the chain through
			if (cfg_reg.daisy_en) begin
				stg1_reg <= '{o: daisy_bit, oe: 1'b1};
			end else begin
				stg1_reg <= '{o: 1'b0, oe: ~cfg_reg.tristate_en};
			end
			stg2_reg <= '{o: l2_bit & emit_bit,
			              oe: (l2_own & emit_bit) | ~cfg_reg.tristate_en};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			emit_d_reg <= 1'b0;
		end else begin
			emit_d_reg <= emit_bit | emit_idle;
		end
	end

	// late mode holds data an extra half cycle
	assign copy = cfg_reg.late_latch ? sample : emit_d_reg;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_sdout               <= 1'b0;
			o_sdout_oe            <= 1'b0;
			o_multipurpose_pin    <= 1'b0;
			o_multipurpose_pin_oe <= 1'b0;
			o_general_output_pin  <= 1'b0;
		end else if (copy) begin
			o_sdout    <= stg1_reg.o;
			o_sdout_oe <= stg1_reg.oe;
			// lane 2 on shared or output pin
			if (cfg_reg.lane2_en & cfg_reg.lane2_on_mp) begin
				o_multipurpose_pin    <= stg2_reg.o;
				o_multipurpose_pin_oe <= stg2_reg.oe;
			end else begin
				o_multipurpose_pin    <= 1'b0;
				o_multipurpose_pin_oe <= 1'b0;
			end
			o_general_output_pin <= cfg_reg.lane2_en & ~cfg_reg.lane2_on_mp
			                        & stg2_reg.o;
		end
	end

	// holder keeps the last driven level
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_sdout_keep    <= 1'b0;
			o_sdout_keep_en <= 1'b0;
		end else begin
			if (o_sdout_oe) begin
				o_sdout_keep <= o_sdout;
			end
			// track the next enable so holder and driver never overlap
			o_sdout_keep_en <= cfg_reg.holder_en
			                   & ~(copy ? stg1_reg.oe : o_sdout_oe);
		end
	end

endmodule

// file: rtl/ast_pkg.sv
/*
 * Shared constants and types of the audio serial transmit framer.
 * Assumes a single system clock; all widths are fixed here.
 */
package ast_pkg;

	localparam int NUM_CH = 4;

	// frame format codes
	localparam logic [1:0] FMT_TDM = 2'h0;
	localparam logic [1:0] FMT_I2S = 2'h1;
	localparam logic [1:0] FMT_LJ  = 2'h2;

	// word length codes and last bit index per code
	localparam logic [1:0] WLEN_16 = 2'h0;
	localparam logic [1:0] WLEN_20 = 2'h1;
	localparam logic [1:0] WLEN_24 = 2'h2;
	localparam logic [1:0] WLEN_32 = 2'h3;
	localparam logic [4:0] WTOP_16 = 5'h0f;
	localparam logic [4:0] WTOP_20 = 5'h13;
	localparam logic [4:0] WTOP_24 = 5'h17;
	localparam logic [4:0] WTOP_32 = 5'h1f;

	// slot numbering
	localparam logic [5:0] SLOT_LEFT0  = 6'h00;
	localparam logic [5:0] SLOT_RIGHT0 = 6'h20;
	localparam logic [5:0] SLOT_LAST   = 6'h3f;
	localparam logic [4:0] HALF_LAST   = 5'h1f;

	// byte addresses
	localparam logic [4:0] ADDR_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_SLOT   = 5'h04;
	localparam logic [4:0] ADDR_DATA0  = 5'h08;
	localparam logic [4:0] ADDR_DATA1  = 5'h0c;
	localparam logic [4:0] ADDR_DATA2  = 5'h10;
	localparam logic [4:0] ADDR_DATA3  = 5'h14;
	localparam logic [4:0] ADDR_STATUS = 5'h18;

	// slot register: one channel per byte
	localparam int SLOT_STRIDE = 8;
	localparam int CTRL_BITS   = 23;

	typedef struct packed {
		logic                enable;
		logic [NUM_CH-1:0]   ch_en;
		logic                daisy_on_mp;
		logic                daisy_en;
		logic                lane2_on_mp;
		logic                lane2_en;
		logic                late_latch;
		logic                holder_en;
		logic                tristate_en;
		logic                bit_clock_invert;
		logic                frame_sync_invert;
		logic [4:0]          slot_delay;
		logic [1:0]          word_length_select;
		logic [1:0]          frame_format_select;
	} ast_cfg_t;

	localparam logic [CTRL_BITS-1:0] CTRL_RST = 23'h00000c;

	typedef struct packed {
		logic o;
		logic oe;
	} ast_lane_t;

	typedef enum logic [1:0] {AST_IDLE, AST_DELAY, AST_SHIFT} ast_state_t;

endpackage

// file: rtl/ast_sync.sv
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes inputs are asynchronous levels; bits are not coherent.
 */
module ast_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	// levels
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			meta_reg <= '0;
			o_q      <= '0;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end

endmodule

// file: rtl/ast_chan_sel.sv
/*
 * Picks the data bit for the current slot and bit from the channels.
 * Pure combinational; assumes words are MSB-aligned at bit 31.
 */
module ast_chan_sel #(
	parameter int N_CH = 4
) (
	// position
	input  wire logic [5:0]             i_slot,
	input  wire logic [4:0]             i_bit,
	// channel setup
	input  wire logic [N_CH-1:0][5:0]   i_slots,
	input  wire logic [N_CH-1:0][31:0]  i_words,
	input  wire logic [N_CH-1:0]        i_ch_en,
	input  wire logic                   i_lane2_en,
	// per-lane result
	output logic                        o_l1_own,
	output logic                        o_l1_bit,
	output logic                        o_l2_own,
	output logic                        o_l2_bit
);

	logic [N_CH-1:0] hit;
	logic [N_CH-1:0] val;
	logic [N_CH-1:0] on_l2;

	genvar n;
	generate
		for (n = 0; n < N_CH; n++) begin : g_ch
			assign hit[n]   = i_ch_en[n] & (i_slots[n] == i_slot);
			assign val[n]   = i_words[n][~i_bit];
			assign on_l2[n] = i_lane2_en & (n >= N_CH / 2);
		end
	endgenerate

	assign o_l1_own = |(hit & ~on_l2);
	assign o_l1_bit = |(hit & ~on_l2 & val);
	assign o_l2_own = |(hit & on_l2);
	assign o_l2_bit = |(hit & on_l2 & val);

endmodule

// file: tb/ast_tx_assertions.sv
/* Port-level checks on ast_tx: bus handshake, pin timing, holder.
 * Sees only the top ports; bound to ast_tx after the module. */
module ast_tx_assertions (
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_resetn,
	// register bus
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	// audio link
	input wire logic        i_bclk,
	input wire logic        o_sdout,
	input wire logic        o_sdout_oe,
	input wire logic        o_sdout_keep,
	input wire logic        o_sdout_keep_en
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       bclk_reg;
	logic [3:0] since_reg;
	// pins may only move a few clocks after a bit-clock edge
	always_ff @(posedge i_clk) begin
		bclk_reg <= i_bclk;
		// a register write may flip the bit clock polarity: an edge too
		if (!i_resetn || bclk_reg != i_bclk ||
		    (i_avs_write && !o_avs_waitrequest))
			since_reg <= 4'h0;
		else if (since_reg != 4'hf)
			since_reg <= since_reg + 4'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	AST_TAKE: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=>
		!o_avs_waitrequest) else $error("request not answered");
	AST_ONE_WAIT: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer longer than one cycle");
	AST_NO_REQ: assert property (
		!(i_avs_read || i_avs_write) && o_avs_waitrequest |=>
		o_avs_waitrequest) else $error("answer without request");
	AST_RDATA: assert property (
		$changed(o_avs_readdata) |-> !o_avs_waitrequest)
		else $error("read data moved outside an answer");
	AST_SD_EDGE: assert property (
		$changed(o_sdout) |-> since_reg <= 4'h6)
		else $error("data moved away from a bit clock edge");
	AST_OE_EDGE: assert property (
		$changed(o_sdout_oe) |-> since_reg <= 4'h6)
		else $error("drive enable moved away from an edge");
	AST_KEEP_EXCL: assert property (
		o_sdout_keep_en |-> !o_sdout_oe)
		else $error("holder active while driving");
	AST_KEEP_HOLD: assert property (
		o_sdout_keep_en && $past(o_sdout_keep_en) |->
		$stable(o_sdout_keep)) else $error("held level changed");
endmodule

bind ast_tx ast_tx_assertions u_ast_tx_assertions (
	.i_clk(i_clk),
	.i_resetn(i_resetn),
	.i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.i_bclk(i_bclk),
	.o_sdout(o_sdout),
	.o_sdout_oe(o_sdout_oe),
	.o_sdout_keep(o_sdout_keep),
	.o_sdout_keep_en(o_sdout_keep_en)
);

// file: tb/ast_host_model.sv
/* Host at the far side of the link: makes bit clock and frame sync
 * for two frames per go, samples the data pin at both edges.
 * Assumes len fits the capture arrays; clock idles between bursts. */
module ast_host_model (
	// frame setup
	input  wire logic          i_go,
	input  wire logic [1:0]    i_fmt,
	input  wire logic [10:0]   i_len,
	input  wire logic [10:0]   i_sync_w,
	input  wire logic          i_bpol,
	input  wire logic          i_fpol,
	// framer data pin
	input  wire logic          i_sdout,
	input  wire logic          i_oe,
	// link pins and captures
	output logic               o_bclk = 1'b0,
	output logic               o_frame_sync = 1'b0,
	output logic [1279:0]      o_cap,
	output logic [1279:0]      o_cap_oe,
	output logic [1279:0]      o_cap_late,
	output logic               o_busy = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	// sync pulse width and half phases
	function automatic logic fs_at(input int k);
		if (i_fmt == ast_pkg::FMT_TDM)
			return k < i_sync_w;
		if (i_fmt == ast_pkg::FMT_I2S)
			return k >= i_len / 2;
		return k < i_len / 2;
	endfunction
	always @(posedge i_go) begin
		logic lv;
		lv = (i_fmt == ast_pkg::FMT_TDM) ^ i_bpol;
		o_busy = 1'b1;
		o_bclk = ~lv;
		o_frame_sync = fs_at(i_len - 1) ^ i_fpol;
		// keeps pin edges and captures off the system clock edges
		#1001;
		repeat (2) begin
			for (int k = 0; k < i_len; k++) begin
				o_cap_late[k] = i_sdout;
				o_bclk = lv;
				o_frame_sync = fs_at(k) ^ i_fpol;
				#62.5;
				o_bclk = ~lv;
				o_cap[k] = i_sdout;
				o_cap_oe[k] = i_oe;
				#62.5;
			end
		end
		#1000;
		o_busy = 1'b0;
	end
endmodule

// file: tb/tb_top.sv
/* Self-checking bench for ast_tx: register access, then frames in
 * each format against the host model. Random words from an LFSR. */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0, i_resetn = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [4:0] adr = 5'h0;
	logic [31:0] wd = 32'h0, rs = 32'h637254f6;
	logic [3:0] ben = 4'h0;
	logic mp_i = 1'b0, gpi = 1'b0, go = 1'b0, hbp = 1'b0, hfp = 1'b0;
	logic [1:0] hf = 2'h0, l2m = 2'h0;
	logic [10:0] hlen = 11'h10, hsw = 11'h1;
	wire logic [31:0] rdata;
	wire logic wreq, sd, sd_oe, bclk, fs, hbusy;
	wire logic mpo, mpo_oe, gpo, hsd, hoe;
	wire logic [1279:0] cap, cap_oe, cap_late;
	ast_pkg::ast_cfg_t cfg;
	logic [5:0] sl [4];
	logic [31:0] dw [4];
	logic dbit;
	int wl, dd, h, ns, n_errors = 0, n_checks = 0;

	always #5 i_clk = ~i_clk;

	ast_tx u_ast_tx (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(ben),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_bclk(bclk), .i_frame_sync(fs), .o_sdout(sd),
		.o_sdout_oe(sd_oe), .o_sdout_keep(), .o_sdout_keep_en(),
		.i_multipurpose_pin(mp_i), .o_multipurpose_pin(mpo),
		.o_multipurpose_pin_oe(mpo_oe), .o_general_output_pin(gpo),
		.i_general_input_pin(gpi));
	// host listens to lane 2 while it is on
	assign hsd = l2m[0] ? (l2m[1] ? mpo : gpo) : sd;
	assign hoe = l2m[0] ? (l2m[1] ? mpo_oe : 1'b1) : sd_oe;
	ast_host_model u_ast_host_model (.i_go(go), .i_fmt(hf),
		.i_len(hlen), .i_sync_w(hsw), .i_bpol(hbp), .i_fpol(hfp),
		.i_sdout(hsd), .i_oe(hoe), .o_bclk(bclk),
		.o_frame_sync(fs), .o_cap(cap), .o_cap_oe(cap_oe),
		.o_cap_late(cap_late), .o_busy(hbusy));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string m);
		n_checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s %h %h", $time, m, s, e);
		end
	endtask

	task automatic bus(input logic we, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] b,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		adr <= a;
		wd <= d;
		ben <= b;
		wr <= we;
		rd <= !we;
		do begin
			@(posedge i_clk);
			n++;
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(32'(n), 32'h2, "bus answer");
	endtask

	// returns {checked, drive, data} for sample k of a frame
	function automatic logic [2:0] expect_at(input int k);
		int p, s, b;
		logic hi, own, d;
		hi = cfg.frame_format_select != ast_pkg::FMT_TDM && k >= h;
		p = hi ? k - h : k;
		own = 1'b0;
		d = 1'b0;
		if (p < dd || p >= dd + ns * wl)
			return 3'h0;
		s = (p - dd) / wl + (hi ? 32 : 0);
		b = (p - dd) % wl;
		for (int c = 0; c < 4; c++)
			if (cfg.ch_en[c] && sl[c] == s && (!l2m[0] || c >= 2)) begin
				own = 1'b1;
				d = d | dw[c][31 - b];
			end
		return {1'b1, own | !cfg.tristate_en |
			(l2m[0] ? !l2m[1] : cfg.daisy_en),
			own ? d : !l2m[0] & cfg.daisy_en & dbit};
	endfunction

	task automatic run(input logic [1:0] f, input logic [1:0] w,
		input logic [4:0] dl, input logic bp, input logic fp,
		input logic tr, input logic ho, input logic la,
		input logic dy, input int nsl);
		logic [31:0] q;
		logic [2:0] e;
		int n;
		rs = lfsr(rs);
		cfg = {1'b1, rs[3:0] | {nsl == 64 || l2m[0], 3'h0}, rs[4],
			dy, l2m, la, ho, tr, bp, fp, dl, w, f};
		dbit = rs[5];
		mp_i <= dbit;
		gpi <= dbit;
		wl = (w == ast_pkg::WLEN_32) ? 32 : 16 + 4 * w;
		dd = dl + (f == ast_pkg::FMT_I2S);
		ns = nsl;
		h = dd + ns * wl + 1;
		for (int i = 0; i < 4; i++) begin
			rs = lfsr(rs);
			dw[i] = rs;
			bus(1'b1, 5'(ast_pkg::ADDR_DATA0 + 4 * i), rs, 4'hf, q);
			rs = lfsr(rs);
			sl[i] = (f == ast_pkg::FMT_TDM) ? 6'(rs % nsl)
				: 6'({rs[8], 5'(rs % 3)});
		end
		if (nsl == 64)
			sl[3] = ast_pkg::SLOT_LAST;
		bus(1'b1, ast_pkg::ADDR_SLOT, {2'h0, sl[3], 2'h0, sl[2],
			2'h0, sl[1], 2'h0, sl[0]}, 4'hf, q);
		bus(1'b1, ast_pkg::ADDR_CTRL, {9'h0, cfg}, 4'hf, q);
		hf <= f;
		hbp <= bp;
		hfp <= fp;
		hsw <= 11'(1 + rs % 4);
		hlen <= 11'((f == ast_pkg::FMT_TDM) ? h : 2 * h);
		go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (n < 5 || (hbusy && n < 40000));
		chk(32'(hbusy), 32'h0, "host done");
		for (int k = 0; k < hlen; k++) begin
			e = expect_at(k);
			if (e[2]) begin
				chk(32'(cap_oe[k + la]), 32'(e[1]), "drive");
				if (e[1])
					chk(32'(la ? cap_late[k + 1] : cap[k]), 32'(e[0]),
						"data bit");
			end
		end
	endtask

	initial begin
		#800000;
		n_errors++;
		summarize();
	end

	initial begin
		logic [31:0] q;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 5'(4 * i), 32'h0, 4'h0, q);
			chk(q, i == 0 ? 32'(ast_pkg::CTRL_RST) : 32'h0, "reset");
		end
		bus(1'b1, 5'h1c, 32'hffffffff, 4'hf, q);
		bus(1'b1, ast_pkg::ADDR_STATUS, 32'hffffffff, 4'hf, q);
		bus(1'b0, 5'h1c, 32'h0, 4'h0, q);
		chk(q, 32'h0, "unmapped");
		bus(1'b0, ast_pkg::ADDR_STATUS, 32'h0, 4'h0, q);
		chk(q, 32'h0, "status write");
		bus(1'b1, ast_pkg::ADDR_DATA0, 32'hffffffff, 4'hf, q);
		bus(1'b1, ast_pkg::ADDR_DATA0, 32'h12345678, 4'h5, q);
		bus(1'b0, ast_pkg::ADDR_DATA0, 32'h0, 4'h0, q);
		chk(q, 32'hff34ff78, "byte lanes");
		// host mostly runs nonzero slot delays
		run(ast_pkg::FMT_TDM, ast_pkg::WLEN_16, 5'h01, 0, 0, 0, 0, 0, 0, 5);
		run(ast_pkg::FMT_TDM, ast_pkg::WLEN_32, 5'h02, 1, 0, 1, 1, 0, 0, 5);
		run(ast_pkg::FMT_I2S, ast_pkg::WLEN_24, 5'h00, 0, 1, 1, 0, 0, 0, 3);
		run(ast_pkg::FMT_I2S, ast_pkg::WLEN_20, 5'h03, 1, 0, 0, 0, 0, 1, 3);
		// lane 2 on the shared pin, then on the output pin
		l2m = 2'h3;
		run(ast_pkg::FMT_LJ, ast_pkg::WLEN_16, 5'h01, 0, 0, 1, 1, 0, 0, 3);
		l2m = 2'h0;
		run(ast_pkg::FMT_LJ, ast_pkg::WLEN_32, 5'h1f, 1, 1, 0, 0, 1, 0, 3);
		l2m = 2'h1;
		run(ast_pkg::FMT_TDM, ast_pkg::WLEN_16, 5'h01, 0, 1, 0, 0, 1, 0, 5);
		l2m = 2'h0;
		run(ast_pkg::FMT_TDM, ast_pkg::WLEN_16, 5'h01, 0, 0, 0, 0, 0, 1, 64);
		summarize();
	end
endmodule
